// ### rtl/lat_table_map.vh
// constants of the sdr read latency table and its sequencer
`ifndef LAT_TABLE_MAP_VH
`define LAT_TABLE_MAP_VH

// parameter block header, offsets 00h..11h, byte 00h leftmost
`define FLT_HDR_BYTES 18
`define FLT_HDR 144'h90_56_06_0e_46_43_03_13_0b_0c_3b_3c_6b_6c_bb_bc_eb_ec

// row layout: frequency byte, code byte, then mode/dummy pairs per command
`define FLT_ROW_BYTES 14
`define FLT_ROWS 5
`define FLT_ROW2 112'h32_03_00_00_00_00_00_00_00_00_00_04_02_01
`define FLT_ROW3 112'h50_00_ff_ff_00_08_00_08_00_08_00_04_02_04
`define FLT_ROW4 112'h5a_01_ff_ff_00_08_00_08_00_08_00_05_02_04
`define FLT_ROW5 112'h68_02_ff_ff_00_08_00_08_00_08_00_06_02_05
`define FLT_ROW6 112'h85_02_ff_ff_00_08_ff_ff_ff_ff_ff_ff_ff_ff

// total block length in bytes and the answer beyond it
`define FLT_BLK_BYTES 88
`define FLT_OOR_BYTE 8'hff
`define FLT_UNSUP 8'hff

// byte offsets inside a row
`define FLT_COL_FREQ 0
`define FLT_COL_CODE 1
`define FLT_COL_FIRST 2

// opcode byte offsets inside the header
`define FLT_HDR_OP_FIRST 6
`define FLT_CMDS 7

// query answer latency in clocks
`define FLT_QRY_LAT 1

`endif

// ### rtl/lat_table_rom.v
// read-only byte image of the sdr latency parameter block
`timescale 1ns/100ps
`include "lat_table_map.vh"

module lat_table_rom #(
  parameter AW = 7
) (
  // byte select
  input wire [AW-1:0] addr,
  // byte out
  output wire [7:0] data
);

  localparam BLK_W = 8 * `FLT_BLK_BYTES;
  // top bit index of the block, held at the width of the offset arithmetic
  localparam [9:0] BLK_TOP = BLK_W - 1;

  // whole block kept as one constant vector, byte 00h in the top bits
  wire [BLK_W-1:0] blk = {`FLT_HDR, `FLT_ROW2, `FLT_ROW3, `FLT_ROW4, `FLT_ROW5,
    `FLT_ROW6};

  wire in_range = ({1'b0, addr} < `FLT_BLK_BYTES);
  wire [9:0] bit_hi = BLK_TOP - {addr, 3'b000};

  // reads past the block answer erased-flash style
  assign data = in_range ? blk[bit_hi -: 8] : `FLT_OOR_BYTE;

endmodule // lat_table_rom

// ### rtl/sdr_read_latency_table.v
// sdr read latency table: query byte port and read phase sequencer
`timescale 1ns/100ps
`include "lat_table_map.vh"

module sdr_read_latency_table #(
  parameter QAW = 7
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST_B,
  // query byte port
  input wire QRY_RD,
  input wire [QAW-1:0] QRY_ADDR,
  output reg [7:0] QRY_DATA,
  output reg QRY_ACK,
  // latency code from the configuration logic
  input wire [1:0] LAT_CODE,
  // read command control from the spi front end
  input wire CMD_GO,
  input wire [7:0] CMD_OP,
  input wire SCK_TICK,
  input wire CMD_END,
  // phase outputs
  output reg MODE_PHASE,
  output reg DUMMY_PHASE,
  output reg DATA_PHASE,
  output reg DATA_START,
  output reg CMD_REJECT,
  output reg [7:0] MODE_CYC,
  output reg [7:0] DUMMY_CYC
);

  ////////////////////////////////////////////////////////////////////////////
  // query port

  wire [7:0] rom_byte;

  lat_table_rom #(
    .AW(QAW)
  ) u_rom (
    .addr(QRY_ADDR),
    .data(rom_byte)
  );

  // one clock from strobe to answer, data held until the next read
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      QRY_DATA <= 8'h00;
      QRY_ACK <= 1'b0;
    end else begin
      QRY_ACK <= QRY_RD;
      if (QRY_RD) begin
        QRY_DATA <= rom_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup helpers

  localparam ROW_W = 8 * `FLT_ROW_BYTES;
  localparam [ROW_W-1:0] ROW_C11 = `FLT_ROW2;
  localparam [ROW_W-1:0] ROW_C00 = `FLT_ROW3;
  localparam [ROW_W-1:0] ROW_C01 = `FLT_ROW4;
  localparam [ROW_W-1:0] ROW_C10 = `FLT_ROW5;
  localparam [8*`FLT_HDR_BYTES-1:0] HDR = `FLT_HDR;
  // index constants sized to the arithmetic that uses them
  localparam [7:0] ROW_TOP = ROW_W - 1;
  localparam [7:0] HDR_TOP = 8 * `FLT_HDR_BYTES - 1;
  localparam [4:0] OP_FIRST = `FLT_HDR_OP_FIRST;
  localparam [3:0] COL_FIRST = `FLT_COL_FIRST;

  // row six shares code 10b with row five; the sequencer follows row five,
  // whose fast read figures equal row six, so nothing is lost at 133 MHz
  function [ROW_W-1:0] row_of;
    input [1:0] code;
    begin
      case (code)
        2'b11: row_of = ROW_C11;
        2'b00: row_of = ROW_C00;
        2'b01: row_of = ROW_C01;
        2'b10: row_of = ROW_C10;
        default: row_of = ROW_C11;
      endcase
    end
  endfunction

  function [7:0] row_byte;
    input [ROW_W-1:0] row;
    input [3:0] idx;
    reg [7:0] hi;
    begin
      hi = ROW_TOP - {1'b0, idx, 3'b000};
      row_byte = row[hi -: 8];
    end
  endfunction

  function [7:0] hdr_byte;
    input [4:0] idx;
    reg [7:0] hi;
    begin
      hi = HDR_TOP - {idx, 3'b000};
      hdr_byte = hdr_byte_sel(hi);
    end
  endfunction

  function [7:0] hdr_byte_sel;
    input [7:0] hi;
    begin
      hdr_byte_sel = HDR[hi -: 8];
    end
  endfunction

  // opcode to column: both address widths of one command share a column
  reg [2:0] col;
  reg col_ok;
  integer k;
  always @* begin
    col = 3'd0;
    col_ok = 1'b0;
    for (k = 0; k < 2 * `FLT_CMDS; k = k + 1) begin
      if (CMD_OP == hdr_byte(OP_FIRST + k[4:0])) begin
        col = k[3:1];
        col_ok = 1'b1;
      end
    end
  end

  wire [ROW_W-1:0] cur_row = row_of(LAT_CODE);
  wire [3:0] mode_idx = COL_FIRST + {col, 1'b0};
  wire [7:0] mode_lu = row_byte(cur_row, mode_idx);
  wire [7:0] dummy_lu = row_byte(cur_row, mode_idx + 4'd1);
  wire unsup = (mode_lu == `FLT_UNSUP) || (dummy_lu == `FLT_UNSUP) || !col_ok;

  ////////////////////////////////////////////////////////////////////////////
  // read phase sequencer

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_MODE = 5'b00010;
  localparam [4:0] S_DUMMY = 5'b00100;
  localparam [4:0] S_DATA = 5'b01000;
  localparam [4:0] S_REJ = 5'b10000;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [7:0] dummy_q;
  reg [7:0] dummy_d;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    dummy_d = dummy_q;
    case (state_q)
      S_IDLE: begin
        if (CMD_GO) begin
          dummy_d = dummy_lu;
          if (unsup) begin
            state_d = S_REJ;
          end else if (mode_lu != 8'h00) begin
            state_d = S_MODE;
            cnt_d = mode_lu;
          end else if (dummy_lu != 8'h00) begin
            state_d = S_DUMMY;
            cnt_d = dummy_lu;
          end else begin
            state_d = S_DATA;
          end
        end
      end
      S_MODE: begin
        if (SCK_TICK) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            // mode bits done; dummy phase next or straight to data
            if (dummy_q != 8'h00) begin
              state_d = S_DUMMY;
              cnt_d = dummy_q;
            end else begin
              state_d = S_DATA;
            end
          end
        end
      end
      S_DUMMY: begin
        if (SCK_TICK) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_d = S_DATA;
          end
        end
      end
      S_DATA: begin
        state_d = S_DATA;
      end
      S_REJ: begin
        state_d = S_REJ;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // end of frame wins over the state and count updates, so a cut command never hangs
    if (CMD_END) begin
      state_d = S_IDLE;
      cnt_d = 8'h00;
    end
  end

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= S_IDLE;
      cnt_q <= 8'h00;
      dummy_q <= 8'h00;
      MODE_PHASE <= 1'b0;
      DUMMY_PHASE <= 1'b0;
      DATA_PHASE <= 1'b0;
      DATA_START <= 1'b0;
      CMD_REJECT <= 1'b0;
      MODE_CYC <= 8'h00;
      DUMMY_CYC <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dummy_q <= dummy_d;
      MODE_PHASE <= (state_d == S_MODE);
      DUMMY_PHASE <= (state_d == S_DUMMY);
      DATA_PHASE <= (state_d == S_DATA);
      DATA_START <= (state_d == S_DATA) && (state_q != S_DATA);
      CMD_REJECT <= (state_d == S_REJ) && (state_q != S_REJ);
      if (CMD_GO && (state_q == S_IDLE)) begin
        MODE_CYC <= mode_lu;
        DUMMY_CYC <= dummy_lu;
      end
    end
  end

endmodule // sdr_read_latency_table

// ### sim/sdr_read_latency_table_assertions.sv
// port-level assertions for the sdr read latency table
`timescale 1ns/100ps
module sdr_read_latency_table_assertions #(parameter QAW = 7) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST_B,
  // query port
  input wire QRY_RD,
  input wire [QAW-1:0] QRY_ADDR,
  input wire [7:0] QRY_DATA,
  input wire QRY_ACK,
  // sequencer
  input wire [1:0] LAT_CODE,
  input wire CMD_GO,
  input wire [7:0] CMD_OP,
  input wire CMD_END,
  input wire MODE_PHASE,
  input wire DUMMY_PHASE,
  input wire DATA_PHASE,
  input wire DATA_START,
  input wire CMD_REJECT,
  input wire [7:0] MODE_CYC,
  input wire [7:0] DUMMY_CYC
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // go is only meaningful from idle; the host never sends it mid-frame
  wire go = CMD_GO & ~CMD_END;
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (QRY_RD |=> QRY_ACK) else $error("no ack");
  chk_id_byte: assert property (QRY_RD && QRY_ADDR == 0 |=> QRY_DATA == 8'h90)
    else $error("bad id");
  chk_oor_ff: assert property (QRY_RD && QRY_ADDR >= 'h58 |=> QRY_DATA == 8'hff)
    else $error("bad oor");
  chk_plain_rej: assert property (go && CMD_OP == 8'h03 && LAT_CODE != 2'b11 |=>
    CMD_REJECT && !MODE_PHASE && !DUMMY_PHASE) else $error("no reject");
  chk_quad_fast: assert property (go && CMD_OP == 8'heb && LAT_CODE == 2'b11 |=>
    MODE_PHASE && MODE_CYC == 8'h02 && DUMMY_CYC == 8'h01) else $error("bad quad");
  chk_fast_dummy: assert property (go && CMD_OP == 8'h0b && LAT_CODE != 2'b11 |=>
    DUMMY_PHASE && DUMMY_CYC == 8'h08) else $error("bad fast");
  chk_end_clear: assert property (CMD_END |=> !(MODE_PHASE || DUMMY_PHASE || DATA_PHASE))
    else $error("phase left");
  chk_start_once: assert property (DATA_START && !CMD_END |=> DATA_PHASE && !DATA_START)
    else $error("bad start");
  cover property (DATA_START);
  cover property (CMD_REJECT);
  cover property (QRY_ACK && QRY_DATA == 8'hff);
endmodule // sdr_read_latency_table_assertions

// ### sim/spi_host_model.sv
// spi host controller model issuing read frames
`timescale 1ns/100ps
module spi_host_model (
  // clock
  input wire clk,
  // frame controls
  output reg [1:0] lat_code,
  output reg cmd_go,
  output reg [7:0] cmd_op,
  output reg sck_tick,
  output reg cmd_end
);
  initial {lat_code, cmd_go, cmd_op, sck_tick, cmd_end} = 13'h0000;
  // plain read at codes 00b-10b is sent only when a test wants a refusal
  task frame(input [7:0] op, input [1:0] code, input integer n);
    integer i;
    begin
      @(posedge clk);
      lat_code <= code;
      cmd_op <= op;
      cmd_go <= 1'b1;
      @(posedge clk);
      cmd_go <= 1'b0;
      // opcode no longer qualified: show junk, not the old value
      cmd_op <= ~op;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        sck_tick <= 1'b1;
        @(posedge clk);
        sck_tick <= 1'b0;
      end
      @(posedge clk);
      cmd_end <= 1'b1;
      @(posedge clk);
      cmd_end <= 1'b0;
    end
  endtask
endmodule // spi_host_model

// ### sim/sdr_read_latency_table_tb.sv
// self-checking testbench for the sdr read latency table
`timescale 1ns/100ps
module sdr_read_latency_table_tb;
  // expected block: header, then rows two to six
  localparam [703:0] BLK = {144'h9056060e464303130b0c3b3c6b6cbbbcebec,
    112'h3203000000000000000000040201, 112'h5000ffff000800080008000402_04,
    112'h5a01ffff00080008000800050204, 112'h6802ffff00080008000800060205,
    112'h8502ffff0008ffffffffffffffff};
  reg CLK_SYS = 1'b0;
  reg RST_B = 1'b0;
  reg QRY_RD = 1'b0;
  reg [6:0] QRY_ADDR = 7'h00;
  wire [7:0] QRY_DATA, CMD_OP, MODE_CYC, DUMMY_CYC;
  wire [1:0] LAT_CODE;
  wire QRY_ACK, CMD_GO, SCK_TICK, CMD_END, MODE_PHASE, DUMMY_PHASE;
  wire DATA_PHASE, DATA_START, CMD_REJECT;
  integer mismatches = 0, num_checks = 0, mc, dc, ds, rj;
  always #5 CLK_SYS = ~CLK_SYS;
  sdr_read_latency_table u_sdr_read_latency_table (.CLK_SYS, .RST_B, .QRY_RD, .QRY_ADDR,
    .QRY_DATA, .QRY_ACK, .LAT_CODE, .CMD_GO, .CMD_OP, .SCK_TICK, .CMD_END, .MODE_PHASE,
    .DUMMY_PHASE, .DATA_PHASE, .DATA_START, .CMD_REJECT, .MODE_CYC, .DUMMY_CYC);
  spi_host_model u_spi_host_model (.clk(CLK_SYS), .lat_code(LAT_CODE), .cmd_go(CMD_GO),
    .cmd_op(CMD_OP), .sck_tick(SCK_TICK), .cmd_end(CMD_END));
  // ticks seen in the mode and dummy phases, data starts and refusals, sampled as the design sees them
  always @(posedge CLK_SYS) begin
    if (MODE_PHASE && SCK_TICK) mc = mc + 1;
    if (DUMMY_PHASE && SCK_TICK) dc = dc + 1;
    if (DATA_START) ds = ds + 1;
    if (CMD_REJECT) rj = rj + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // whole block plus two bytes past its end
  task t_query;
    integer a;
    begin
      for (a = 0; a < 90; a = a + 1) begin
        @(posedge CLK_SYS);
        QRY_RD <= 1'b1;
        QRY_ADDR <= a[6:0];
        @(posedge CLK_SYS);
        QRY_RD <= 1'b0;
        QRY_ADDR <= ~a[6:0];
        #1;
        chk({7'h00, QRY_ACK}, 8'h01);
        chk(QRY_DATA, a < 88 ? BLK[703-8*a -: 8] : 8'hff);
      end
      $display("test query done");
    end
  endtask
  // every command of every code, counts taken from the expected block
  task t_reads;
    integer c, k, r, m, d;
    begin
      for (c = 0; c < 4; c = c + 1)
        for (k = 0; k < 12; k = k + 1) begin
          r = 20 + 14 * ((c + 1) % 4) + 2 * (k / 2);
          m = BLK[703-8*r -: 8];
          d = BLK[695-8*r -: 8];
          {mc, dc, ds, rj} = 128'h0;
          u_spi_host_model.frame(BLK[655-8*k -: 8], c[1:0], m == 255 ? 0 : m + d + 2);
          chk(mc[7:0], m == 255 ? 8'h00 : m[7:0]);
          chk(dc[7:0], m == 255 ? 8'h00 : d[7:0]);
          chk(ds[7:0], {7'h00, m != 255});
          chk(rj[7:0], {7'h00, m == 255});
          chk(MODE_CYC, m[7:0]);
          chk(DUMMY_CYC, d[7:0]);
        end
      $display("test reads done");
    end
  endtask
  task t_unknown;
    begin
      {rj, ds} = 64'h0;
      u_spi_host_model.frame(8'h0d, 2'b11, 4);
      chk(rj[7:0], 8'h01);
      chk(ds[7:0], 8'h00);
      $display("test unknown opcode done");
    end
  endtask
  initial begin
    #(20000 * 10);
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    t_query;
    t_reads;
    t_unknown;
    final_report;
  end
endmodule // sdr_read_latency_table_tb
bind sdr_read_latency_table sdr_read_latency_table_assertions #(.QAW(QAW)) u_chk (.CLK_SYS,
  .RST_B, .QRY_RD, .QRY_ADDR, .QRY_DATA, .QRY_ACK, .LAT_CODE, .CMD_GO, .CMD_OP, .CMD_END,
  .MODE_PHASE, .DUMMY_PHASE, .DATA_PHASE, .DATA_START, .CMD_REJECT, .MODE_CYC, .DUMMY_CYC);
